// >>> rtl/adc_conversion_sequencer.sv
// Purpose: Control logic of a successive-approximation converter
// Assumes: Synchronous inputs, one bus clock, plain register port
// Notes:   Analog front end outside; it returns an 11-bit raw value
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int ASYNC_DIV = 4
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Trigger, clock and power inputs
    input  wire logic        hw_conv_trigger_i,
    input  wire logic        alt_clk_tick_i,
    input  wire logic        stop_i,
    // Analog core
    input  wire logic [10:0] conv_raw_i,
    output logic      [4:0]  channel_o,
    output logic             conv_enable_o,
    output logic             sample_o,
    output logic             sar_run_o,
    output logic             async_clk_en_o,
    output logic             low_power_o,
    // Status
    output logic             conv_active_o,
    output logic             complete_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register strobes and control registers

    cs1_s      cs1_ff;
    cs2_s      cs2_ff;
    conv_cfg_s cfg_ff;
    logic [1:0] cvh_ff;
    logic [7:0] cvl_ff;
    logic       flag_ff;
    logic       block_ff;
    logic       trig_ff;
    logic [9:0] res_ff;
    seq_e       state_ff;
    seq_e       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic       first_ff;
    logic       nxt_first;

    logic wr_cs1;
    logic cfg_wr;
    logic rd_rh;
    logic rd_rl;
    cs1_s new_cs1;
    logic sw_go;

    assign wr_cs1  = ce_i && wr_i && (addr_i == ADDR_CS1);
    assign cfg_wr  = ce_i && wr_i && ((addr_i == ADDR_CS2) || (addr_i == ADDR_CFG)
                     || (addr_i == ADDR_CVH) || (addr_i == ADDR_CVL));
    assign rd_rh   = ce_i && rd_i && (addr_i == ADDR_RH);
    assign rd_rl   = ce_i && rd_i && (addr_i == ADDR_RL);
    assign new_cs1 = cs1_s'(wdata_i[6:0]);
    assign sw_go   = wr_cs1 && (new_cs1.chan != CHAN_OFF) && !cs2_ff.hw_trig;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cs1_ff <= CS1_RST;
            cs2_ff <= CS2_RST;
            cfg_ff <= CFG_RST;
            cvh_ff <= '0;
            cvl_ff <= '0;
        end else if (ce_i && wr_i) begin
            unique case (addr_i)
                ADDR_CS1: cs1_ff <= new_cs1;
                ADDR_CS2: cs2_ff <= cs2_s'({wdata_i[6:4], 4'h0});
                ADDR_CFG: cfg_ff <= conv_cfg_s'(wdata_i);
                ADDR_CVH: cvh_ff <= wdata_i[1:0];
                ADDR_CVL: cvl_ff <= wdata_i;
                default:  ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter clock: source select then divider

    logic       half_ff;
    logic [7:0] async_cnt_ff;
    logic [2:0] div_cnt_ff;
    logic       src_tick;
    logic       converter_clock_tick;
    logic       is_async;
    logic [2:0] div_last;

    assign is_async       = (cfg_ff.clk_sel == CLK_ASYNC);
    assign async_clk_en_o = is_async && (state_ff != S_IDLE);
    assign div_last       = 3'((4'h1 << cfg_ff.div) - 4'h1);

    always_comb begin
        unique case (cfg_ff.clk_sel)
            CLK_BUS:   src_tick = 1'b1;
            CLK_BUS2:  src_tick = half_ff;
            CLK_ALT:   src_tick = alt_clk_tick_i;
            CLK_ASYNC: src_tick = async_clk_en_o && (async_cnt_ff == 8'(ASYNC_DIV - 1));
        endcase
    end

    assign converter_clock_tick = src_tick && (div_cnt_ff == div_last);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            half_ff <= 1'b0;
        end else if (ce_i) begin
            half_ff <= !half_ff;
        end
    end

    // The internal generator only runs while a conversion needs it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !async_clk_en_o) begin
            async_cnt_ff <= '0;
        end else if (ce_i) begin
            async_cnt_ff <= (async_cnt_ff == 8'(ASYNC_DIV - 1)) ? 8'h00 : async_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || state_ff == S_IDLE) begin
            div_cnt_ff <= '0;
        end else if (ce_i && src_tick) begin
            div_cnt_ff <= (div_cnt_ff == div_last) ? 3'h0 : div_cnt_ff + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result rounding and compare

    logic        mode10;
    logic [9:0]  r10;
    logic [7:0]  r8;
    logic [9:0]  res_now;
    logic [9:0]  cv;
    logic [9:0]  diff;
    logic        cmp_ok;
    logic        cmp_fail;
    logic [9:0]  store;

    assign mode10 = (cfg_ff.mode == MODE_10BIT);
    // Saturate so rounding never wraps a full-scale code to zero
    assign r10 = (&conv_raw_i[10:1]) ? conv_raw_i[10:1]
                                     : conv_raw_i[10:1] + 10'(conv_raw_i[0]);
    assign r8  = (&conv_raw_i[10:3]) ? conv_raw_i[10:3]
                                     : conv_raw_i[10:3] + 8'(conv_raw_i[2]);
    assign res_now  = mode10 ? r10 : {2'h0, r8};
    assign cv       = mode10 ? {cvh_ff, cvl_ff} : {2'h0, cvl_ff};
    assign diff     = res_now + (~cv + 10'h001);
    assign cmp_ok   = cs2_ff.cmp_gt ? (res_now >= cv) : (res_now < cv);
    assign cmp_fail = cs2_ff.cmp_en && !cmp_ok;
    assign store    = cs2_ff.cmp_en ? (mode10 ? diff : {2'h0, diff[7:0]}) : res_now;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    logic trig_rise;
    logic hw_go;
    logic stop_abort;
    logic abort;
    logic sar_end;
    logic do_xfer;
    logic do_block;
    logic [CNT_W-1:0] wake_len;
    logic [CNT_W-1:0] samp_len;
    logic [CNT_W-1:0] sar_len;

    assign trig_rise  = hw_conv_trigger_i && !trig_ff;
    assign hw_go      = ce_i && cs2_ff.hw_trig && trig_rise && (state_ff == S_IDLE)
                        && (cs1_ff.chan != CHAN_OFF);
    assign stop_abort = ce_i && stop_i && !is_async && (state_ff != S_IDLE);
    assign abort      = cfg_wr || stop_abort || (wr_cs1 && !sw_go);
    assign sar_end    = ce_i && (state_ff == S_SAR) && converter_clock_tick && (cnt_ff == '0) && !abort
                        && !wr_cs1;
    assign do_xfer    = sar_end && !cmp_fail && !block_ff;
    assign do_block   = sar_end && !cmp_fail && block_ff;
    assign wake_len   = CNT_W'(BUS_OVH_CYC - 1) + (is_async ? CNT_W'(ASYNC_START_CYC) : '0);
    assign samp_len   = cfg_ff.long_sample ? CNT_W'(SAMPLE_LONG - 1) : CNT_W'(SAMPLE_SHORT - 1);
    assign sar_len    = mode10 ? CNT_W'(SAR_10BIT - 1) : CNT_W'(SAR_8BIT - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_first = first_ff;
        if (abort) begin
            nxt_state = S_IDLE;
        end else if (sw_go || hw_go) begin
            nxt_state = S_WAKE;
            nxt_cnt   = wake_len;
            nxt_first = 1'b1;
        end else if (ce_i) begin
            unique case (state_ff)
                S_IDLE: ;
                S_WAKE: begin
                    if (cnt_ff == '0) begin
                        nxt_state = S_SETUP;
                        nxt_cnt   = CNT_W'(SETUP_CONVERTER_CLOCK - 1);
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                S_SETUP, S_SAMPLE: begin
                    if (converter_clock_tick && cnt_ff == '0) begin
                        nxt_state = (state_ff == S_SETUP) ? S_SAMPLE : S_SAR;
                        nxt_cnt   = (state_ff == S_SETUP) ? samp_len : sar_len;
                    end else if (converter_clock_tick) begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                S_SAR: begin
                    if (sar_end) begin
                        // Blocking forces a retry; a failed single compare just stops
                        if (cs1_ff.cont || do_block) begin
                            nxt_state = S_SAMPLE;
                            nxt_cnt   = samp_len;
                            nxt_first = 1'b0;
                        end else begin
                            nxt_state = S_IDLE;
                        end
                    end else if (converter_clock_tick) begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= S_IDLE;
            cnt_ff   <= '0;
            first_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            first_ff <= nxt_first;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            trig_ff <= 1'b0;
        end else if (ce_i) begin
            trig_ff <= hw_conv_trigger_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result, flag and blocking

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            res_ff <= '0;
        end else if (do_xfer) begin
            res_ff <= store;
        end
    end

    // A transfer in the same cycle as a clearing access keeps the flag set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flag_ff <= 1'b0;
        end else if (do_xfer) begin
            flag_ff <= 1'b1;
        end else if (wr_cs1 || rd_rl) begin
            flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            block_ff <= 1'b0;
        end else if (rd_rl) begin
            block_ff <= 1'b0;
        end else if (rd_rh && mode10) begin
            block_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                unique case (addr_i)
                    ADDR_CS1: rdata_o <= {flag_ff, cs1_ff};
                    ADDR_CS2: rdata_o <= {state_ff != S_IDLE, cs2_ff};
                    ADDR_RH:  rdata_o <= {6'h00, res_ff[9:8]};
                    ADDR_RL:  rdata_o <= res_ff[7:0];
                    ADDR_CVH: rdata_o <= {6'h00, cvh_ff};
                    ADDR_CVL: rdata_o <= cvl_ff;
                    ADDR_CFG: rdata_o <= cfg_ff;
                    default:  rdata_o <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign channel_o      = cs1_ff.chan;
    assign conv_enable_o  = (cs1_ff.chan != CHAN_OFF);
    assign sample_o       = (state_ff == S_SAMPLE);
    assign sar_run_o      = (state_ff == S_SAR);
    assign low_power_o    = cfg_ff.low_power;
    assign conv_active_o  = (state_ff != S_IDLE);
    assign complete_irq_o = flag_ff && cs1_ff.irq_en;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_FLAG_ON_XFER: assert property (do_xfer |=> flag_ff && res_ff == $past(store))
        else $error("flag or result missing after transfer");
    AST_BLOCK_HOLDS: assert property (do_block && !flag_ff |=> !flag_ff && $stable(res_ff))
        else $error("blocked transfer changed result or flag");
    AST_CMP_FAIL: assert property (sar_end && cmp_fail |=> $stable(res_ff))
        else $error("failed compare wrote result");
    AST_CFG_ABORT: assert property (cfg_wr |=> state_ff == S_IDLE)
        else $error("configuration write did not abort");
    AST_SW_START: assert property (sw_go && !stop_abort |=> state_ff == S_WAKE && cnt_ff == $past(wake_len))
        else $error("software start not taken");
    AST_CONT_NEXT: assert property (do_xfer && cs1_ff.cont |=> state_ff == S_SAMPLE && !first_ff)
        else $error("continuous mode did not restart");
    // The generator must be parked while idle, not merely gated at its output
    AST_ASYNC_ONLY_ACTIVE: assert property (!conv_active_o |=> async_cnt_ff == '0)
        else $error("async clock on while idle");
    AST_TRIG_IGNORED: assert property ((state_ff != S_IDLE) && (state_ff != S_WAKE) && trig_rise && !wr_i |=> state_ff != S_WAKE)
        else $error("trigger edge restarted running conversion");

    COV_XFER:  cover property (do_xfer ##[1:200] do_xfer);
    COV_BLOCK: cover property (do_block);
    COV_HW:    cover property (hw_go ##[1:200] do_xfer);

endmodule

`default_nettype wire

// >>> pkg/adc_seq_pkg.sv
// Purpose: Shared constants and types of the conversion sequencer
// Assumes: 125 MHz bus clock, 8-bit register port
// Notes:   Register offsets are word indices on the plain port
`default_nettype none

package adc_seq_pkg;

    // Timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int ASYNC_START_NS  = 5000;
    localparam int ASYNC_START_CYC = (ASYNC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_OVH_CYC     = 5;
    localparam int SETUP_CONVERTER_CLOCK      = 3;
    localparam int SAMPLE_SHORT    = 3;
    localparam int SAMPLE_LONG     = 23;
    localparam int SAR_8BIT        = 14;
    localparam int SAR_10BIT       = 17;
    localparam int CNT_W           = 10;

    // Register offsets
    localparam logic [2:0] ADDR_CS1 = 3'h0;
    localparam logic [2:0] ADDR_CS2 = 3'h1;
    localparam logic [2:0] ADDR_RH  = 3'h2;
    localparam logic [2:0] ADDR_RL  = 3'h3;
    localparam logic [2:0] ADDR_CVH = 3'h4;
    localparam logic [2:0] ADDR_CVL = 3'h5;
    localparam logic [2:0] ADDR_CFG = 3'h6;

    // Field codes and reset values
    localparam logic [4:0] CHAN_OFF   = 5'h1F;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS    = 2'h0;
    localparam logic [1:0] CLK_BUS2   = 2'h1;
    localparam logic [1:0] CLK_ALT    = 2'h2;
    localparam logic [1:0] CLK_ASYNC  = 2'h3;

    typedef struct packed {
        logic       irq_en;
        logic       cont;
        logic [4:0] chan;
    } cs1_s;

    typedef struct packed {
        logic hw_trig;
        logic cmp_en;
        logic cmp_gt;
        logic [3:0] rsvd;
    } cs2_s;

    typedef struct packed {
        logic       low_power;
        logic [1:0] div;
        logic       long_sample;
        logic [1:0] mode;
        logic [1:0] clk_sel;
    } conv_cfg_s;

    localparam cs1_s      CS1_RST = '{irq_en: 1'b0, cont: 1'b0, chan: CHAN_OFF};
    localparam cs2_s      CS2_RST = '0;
    localparam conv_cfg_s CFG_RST = '0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_WAKE,
        S_SETUP,
        S_SAMPLE,
        S_SAR
    } seq_e;

endpackage

`default_nettype wire

// >>> bench/analog_model.sv
// Purpose: Analog channel model that feeds raw values to the sequencer
// Assumes: One level per channel, set by the bench before a conversion
// Notes:   Outside the approximation phase the raw bus toggles every cycle
`timescale 1ns/1ps
`default_nettype none

module analog_model (
    // Clock
    input  wire logic        clk_i,
    // Sequencer side
    input  wire logic [4:0]  channel_i,
    input  wire logic        sample_i,
    input  wire logic        sar_run_i,
    output logic      [10:0] conv_raw_o
);
    logic [10:0] level [32];
    logic [10:0] held;

    initial begin
        conv_raw_o = 11'h000;
        held = 11'h000;
        foreach (level[k]) level[k] = 11'h000;
    end

    // Level is captured while sampling; later input changes must not leak in
    always @(posedge clk_i) begin
        if (sample_i) begin
            held <= level[channel_i];
        end
        conv_raw_o <= sar_run_i ? held : ~conv_raw_o;
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Clock enable held high; alternate clock ticks every second cycle
// Notes:   Expected results are computed here from the raw channel levels
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import adc_seq_pkg::*;

    localparam int ASYNC_DIV = 4;

    logic        clk, sys_rst, ce, wr, rd, trig, alt_tick, stop;
    logic        en, samp, sar, aclk, lp, act, irq, sar_q, samp_q, ie, ok;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, d, cfg;
    logic [10:0] raw, lv;
    logic [4:0]  chan, ch;
    logic [9:0]  e, cv, r, pr;
    int          err_count, check_count, c;

    adc_conversion_sequencer #(.ASYNC_DIV(ASYNC_DIV)) uut (
        .clk_i(clk), .sys_rst_i(sys_rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hw_conv_trigger_i(trig),
        .alt_clk_tick_i(alt_tick), .stop_i(stop), .conv_raw_i(raw), .channel_o(chan),
        .conv_enable_o(en), .sample_o(samp), .sar_run_o(sar), .async_clk_en_o(aclk),
        .low_power_o(lp), .conv_active_o(act), .complete_irq_o(irq)
    );

    analog_model am (.clk_i(clk), .channel_i(chan), .sample_i(samp), .sar_run_i(sar),
        .conv_raw_o(raw));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) alt_tick <= ~alt_tick;

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic chk_le(input int g, input int x);
        check_count++;
        if (g > x) begin
            err_count++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask

    always @(negedge clk) begin
        if (!sys_rst && sar && !sar_q) chk(8'(samp_q), 8'h01);
        if (aclk) chk(8'(act), 8'h01);
        sar_q <= sar;
        samp_q <= samp;
    end

    function automatic logic [9:0] rnd(input logic [10:0] v, input logic m10);
        if (!m10) return {2'h0, v[10:3]};
        if (v == 11'h7FF) return 10'h3FF;
        return 10'((12'(v) + 12'h001) >> 1);
    endfunction

    // Upper bound in bus cycles; one extra converter clock covers divider phase
    function automatic int lim(input logic [7:0] f, input logic first);
        int m;
        int k;
        m = (f[1:0] == CLK_BUS) ? 1 : (f[1:0] == CLK_ASYNC) ? ASYNC_DIV : 2;
        m = m << f[6:5];
        k = (first ? 20 : 17) + (f[4] ? 20 : 0) + ((f[3:2] == MODE_10BIT) ? 3 : 0);
        k = (k + 1) * m + (first ? BUS_OVH_CYC + 2 : 2);
        return k + ((first && f[1:0] == CLK_ASYNC) ? ASYNC_START_CYC : 0);
    endfunction

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_on(input logic for_irq, inout int n);
        while ((for_irq ? irq !== 1'b1 : act !== 1'b0) && n < 6000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    task automatic conv(input logic [7:0] f, input logic [7:0] s1, input logic [10:0] v);
        logic m10;
        m10 = (f[3:2] == MODE_10BIT);
        if (!m10) v[2:0] = 3'h0;
        am.level[s1[4:0]] = v;
        e = rnd(v, m10);
        wr_reg(ADDR_CFG, f);
        wr_reg(ADDR_CS1, s1);
        chk(8'(aclk), 8'(f[1:0] == CLK_ASYNC));
        chk(8'(lp), 8'(f[7]));
        chk(8'(chan), 8'(s1[4:0]));
        c = 0;
        wait_on(1'b0, c);
        chk_le(c, lim(f, 1'b1));
        rd_reg(ADDR_CS1, d);
        chk(d, s1 | 8'h80);
        chk(8'(irq), 8'(s1[6]));
        rd_reg(ADDR_RH, d);
        chk(d, m10 ? 8'(e[9:8]) : 8'h00);
        rd_reg(ADDR_RL, d);
        chk(d, e[7:0]);
        rd_reg(ADDR_CS1, d);
        chk(d, s1);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(80000 * 8);
        err_count++;
        tally_and_finish();
    end

    initial begin
        err_count = 0;
        check_count = 0;
        {wr, rd, trig, alt_tick, stop, sar_q, samp_q} = '0;
        ce = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        sys_rst = 1'b1;
        void'($urandom(32'h1eee8af3));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk(8'(en), 8'h00);
        rd_reg(ADDR_CS1, d);
        chk(d, 8'h1F);
        for (int a = 1; a < 8; a++) begin
            rd_reg(3'(a), d);
            chk(d, 8'h00);
        end
        // Every clock source at both widths, with random divider and sample length
        for (int i = 0; i < 8; i++) begin
            cfg = {1'($urandom), 2'($urandom), 1'($urandom), i[2] ? MODE_10BIT : 2'h0, 2'(i)};
            ch = 5'($urandom_range(0, 30));
            ie = 1'($urandom);
            conv(cfg, {1'b0, ie, 1'b0, ch}, 11'($urandom));
        end
        // Compare, both directions, condition true and false
        pr = e;
        wr_reg(ADDR_CFG, 8'h08);
        for (int k = 0; k < 4; k++) begin
            lv = 11'($urandom_range(2, 2000)) & 11'h7FE;
            r = lv[10:1];
            cv = k[1] ? r : r + 10'h001;
            ok = k[0] ? k[1] : !k[1];
            am.level[3] = lv;
            wr_reg(ADDR_CVH, 8'(cv[9:8]));
            wr_reg(ADDR_CVL, cv[7:0]);
            wr_reg(ADDR_CS2, {3'b001, 1'(k), 4'h0});
            wr_reg(ADDR_CS1, 8'h03);
            c = 0;
            wait_on(1'b0, c);
            chk_le(c, 60);
            if (ok) pr = r - cv;
            rd_reg(ADDR_CS1, d);
            chk(d, {ok, 7'h03});
            rd_reg(ADDR_RH, d);
            chk(d, 8'(pr[9:8]));
            rd_reg(ADDR_RL, d);
            chk(d, pr[7:0]);
        end
        // Half-read result blocks the next transfer; the conversion repeats
        wr_reg(ADDR_CS2, 8'h00);
        conv(8'h08, 8'h04, 11'h2A6);
        rd_reg(ADDR_RH, d);
        am.level[4] = 11'h0F0;
        wr_reg(ADDR_CS1, 8'h04);
        repeat (33) @(posedge clk);
        #1 chk(8'(act), 8'h01);
        rd_reg(ADDR_CS1, d);
        chk(d, 8'h04);
        rd_reg(ADDR_RL, d);
        chk(d, e[7:0]);
        c = 0;
        wait_on(1'b0, c);
        rd_reg(ADDR_RH, d);
        rd_reg(ADDR_RL, d);
        chk(d, 8'h78);
        // Hardware trigger, continuous
        wr_reg(ADDR_CFG, 8'h00);
        wr_reg(ADDR_CS2, 8'h40);
        am.level[6] = 11'h3C0;
        wr_reg(ADDR_CS1, 8'h66);
        repeat (8) @(posedge clk);
        #1 chk(8'(act), 8'h00);
        trig <= 1'b1;
        c = 0;
        wait_on(1'b1, c);
        chk_le(c, lim(8'h00, 1'b1));
        trig <= 1'b0;
        rd_reg(ADDR_RL, d);
        chk(d, 8'h78);
        trig <= 1'b1;
        c = 0;
        wait_on(1'b1, c);
        chk_le(c, lim(8'h00, 1'b0));
        chk(8'(act), 8'h01);
        wr_reg(ADDR_CS2, 8'h40);
        @(posedge clk);
        #1 chk(8'(act), 8'h00);
        trig <= 1'b0;
        wr_reg(ADDR_CS2, 8'h00);
        // Aborts by writes and stop; async clock survives stop
        am.level[6] = 11'h200;
        for (int j = 0; j < 6; j++) begin
            wr_reg(ADDR_CFG, (j == 5) ? 8'h03 : 8'h00);
            wr_reg(ADDR_CS1, 8'h06);
            repeat (10) @(posedge clk);
            #1;
            case (j)
                0: wr_reg(ADDR_CFG, 8'h00);
                1: wr_reg(ADDR_CVH, 8'h00);
                2: wr_reg(ADDR_CVL, 8'h00);
                3: wr_reg(ADDR_CS1, 8'h1F);
                default: stop <= 1'b1;
            endcase
            repeat (2) @(posedge clk);
            #1 chk(8'(act), 8'(j == 5));
            if (j == 3) chk(8'(en), 8'h00);
            stop <= 1'b0;
            c = 0;
            wait_on(1'b0, c);
            rd_reg(ADDR_RL, d);
            chk(d, (j == 5) ? 8'h40 : 8'h78);
        end
        // Reset in mid-conversion clears the results
        wr_reg(ADDR_CS1, 8'h06);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk(8'(act), 8'h00);
        rd_reg(ADDR_RL, d);
        chk(d, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
